// ==== logic/itt_timer.sv ====
// ---------------------------------------------------------------
// eight-bit interval / clock time-base timer with clock output
// ---------------------------------------------------------------
// assumes one clock mclk; watch clock and power mode are inputs
// already synchronous to mclk; registers reached over APB
`timescale 1ns/100ps

module itt_timer
	import itt_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register bus
	input wire itt_apb_req_type apb_req,
	output itt_apb_rsp_type apb_rsp,
	// surroundings
	input wire logic watch_clk,
	input wire itt_power_type power_mode,
	// interrupt and clock pin
	output logic irq,
	output logic divided_clock_pin,
	output logic divided_clock_pin_en
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// true when the low tap bits are all ones: next increment carries past the tap
	function automatic logic tap_due(input logic [`ITT_SYS_W-1:0] v, input logic [3:0] tap);
		logic [`ITT_SYS_W:0] m;
		m = ({{`ITT_SYS_W{1'b0}}, 1'b1} << tap) - {{`ITT_SYS_W{1'b0}}, 1'b1};
		return (v & m[`ITT_SYS_W-1:0]) == m[`ITT_SYS_W-1:0];
	endfunction

	function automatic logic [3:0] sys_tap(input logic [2:0] sel);
		case (sel)
			3'h0: sys_tap = `ITT_SYS_TAP0;
			3'h1: sys_tap = `ITT_SYS_TAP1;
			3'h2: sys_tap = `ITT_SYS_TAP2;
			3'h3: sys_tap = `ITT_SYS_TAP3;
			3'h4: sys_tap = `ITT_SYS_TAP4;
			3'h5: sys_tap = `ITT_SYS_TAP5;
			3'h6: sys_tap = `ITT_SYS_TAP6;
			default: sys_tap = `ITT_SYS_TAP7;
		endcase
	endfunction

	function automatic logic [3:0] watch_tap(input logic [1:0] sel);
		case (sel)
			2'h0: watch_tap = `ITT_WATCH_TAP0;
			2'h1: watch_tap = `ITT_WATCH_TAP1;
			2'h2: watch_tap = `ITT_WATCH_TAP2;
			default: watch_tap = `ITT_WATCH_TAP3;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	itt_state_type r;
	itt_state_type next_r;

	logic sys_running;
	logic watch_edge;
	logic hold_clear;
	logic tick;
	logic access;
	logic [15:0] index;
	logic [`ITT_SYS_W-1:0] watch_ext;
	logic [2:0] out_bit;
	logic sys_out_bit;
	logic watch_out_bit;

	always_comb begin
		next_r = r;
		sys_running = (power_mode == ITT_PWR_ACTIVE) || (power_mode == ITT_PWR_SLEEP);
		watch_edge = watch_clk && !r.watch_prev;
		watch_ext = {{(`ITT_SYS_W - `ITT_WATCH_W){1'b0}}, r.watch_presc};
		hold_clear = r.mode[`ITT_F_TIMEBASE] && r.mode[`ITT_F_CLEAR];
		tick = 1'b0;
		access = apb_req.psel && apb_req.penable && r.rsp.pready;
		index = apb_req.paddr[`ITT_ADDR_W-1:2];

		// prescalers
		next_r.sys_presc = r.sys_presc + {{(`ITT_SYS_W-1){1'b0}}, 1'b1};
		next_r.watch_prev = watch_clk;
		if (hold_clear) begin
			next_r.watch_presc = '0; // [RULE5]
		end else if (watch_edge) begin
			next_r.watch_presc = r.watch_presc + {{(`ITT_WATCH_W-1){1'b0}}, 1'b1};
		end

		// counting pulse; interval counting halts when the system clock is stopped
		if (!r.mode[`ITT_F_TIMEBASE]) begin
			tick = sys_running && tap_due(r.sys_presc, sys_tap(r.mode[2:0])); // [RULE3]
		end else if (!r.mode[`ITT_F_CLEAR]) begin
			tick = watch_edge && tap_due(watch_ext, watch_tap(r.mode[1:0])); // [RULE4]
		end

		if (hold_clear) begin
			next_r.count = `ITT_COUNT_RESET; // [RULE5]
		end else if (tick) begin
			// wraps FF -> 00 by width [RULE1] [RULE14]
			next_r.count = r.count + 8'h01;
		end
		// flag set on the pulse after FF [RULE6] [RULE13]
		if (tick && !hold_clear && r.count == `ITT_COUNT_MAX) begin
			next_r.ovf_flag = 1'b1;
		end

		// register reads and writes; the set above must survive a same-cycle clear
		next_r.rsp.pready = apb_req.psel && apb_req.penable && !r.rsp.pready;
		next_r.rsp.pslverr = 1'b0;
		next_r.rsp.prdata = '0;
		if (apb_req.psel && apb_req.penable && !r.rsp.pready) begin
			if (index == `ITT_IDX_MODE) begin
				next_r.rsp.prdata[7:0] = r.mode;
			end else if (index == `ITT_IDX_COUNT) begin
				// count reads as zero in every power mode other than active [RULE11]
				next_r.rsp.prdata[7:0] = (power_mode == ITT_PWR_ACTIVE) ? r.count : 8'h00;
			end else if (index == `ITT_IDX_IRQ_STATUS) begin
				next_r.rsp.prdata[`ITT_F_OVF] = r.ovf_flag;
			end else if (index == `ITT_IDX_IRQ_ENABLE) begin
				next_r.rsp.prdata[`ITT_F_OVF] = r.ovf_enable;
			end else if (index == `ITT_IDX_PORT_MODE) begin
				next_r.rsp.prdata[`ITT_F_CLKOUT_EN] = r.clkout_enable;
			end else begin
				next_r.rsp.pslverr = 1'b1;
			end
		end
		if (access && apb_req.pwrite) begin
			if (index == `ITT_IDX_MODE) begin
				next_r.mode = apb_req.pwdata[7:0] | `ITT_MODE_RSVD_MASK; // [RULE9]
			end else if (index == `ITT_IDX_COUNT) begin
				next_r.count = next_r.count; // read-only count [RULE12]
			end else if (index == `ITT_IDX_IRQ_STATUS) begin
				if (apb_req.pwdata[`ITT_F_OVF] && !next_r.ovf_flag) begin
					next_r.ovf_flag = 1'b0;
				end else if (apb_req.pwdata[`ITT_F_OVF] && !(tick && r.count == `ITT_COUNT_MAX)) begin
					next_r.ovf_flag = 1'b0;
				end
			end else if (index == `ITT_IDX_IRQ_ENABLE) begin
				next_r.ovf_enable = apb_req.pwdata[`ITT_F_OVF];
			end else if (index == `ITT_IDX_PORT_MODE) begin
				next_r.clkout_enable = apb_req.pwdata[`ITT_F_CLKOUT_EN];
			end
		end

		// interrupt output
		next_r.irq = r.ovf_flag && r.ovf_enable; // [RULE15]

		// clock output
		out_bit = `ITT_OUT_BIT_BASE - {1'b0, r.mode[6:5]};
		sys_out_bit = r.sys_presc[out_bit];
		watch_out_bit = r.watch_presc[out_bit];
		if (r.mode[`ITT_F_OUT_WATCH]) begin
			next_r.clk_out = r.clkout_enable && watch_out_bit && power_mode != ITT_PWR_SUBSLEEP; // [RULE7] [RULE8]
		end else begin
			next_r.clk_out = r.clkout_enable && sys_out_bit && sys_running; // [RULE7] [RULE8]
		end
		next_r.clk_out_en = r.clkout_enable; // [RULE16]
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.mode <= `ITT_MODE_RESET; // [RULE10]
			r.count <= `ITT_COUNT_RESET; // [RULE2]
		end else begin
			r <= next_r;
		end
	end

	assign apb_rsp = r.rsp;
	assign irq = r.irq;
	assign divided_clock_pin = r.clk_out;
	assign divided_clock_pin_en = r.clk_out_en;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	chk_clear_hold: assert property (hold_clear |=> r.count == `ITT_COUNT_RESET && r.watch_presc == '0) // [RULE5]
		else $error("count or watch prescaler not held clear");
	chk_overflow_flag: assert property (tick && !hold_clear && r.count == `ITT_COUNT_MAX
		|=> r.ovf_flag && r.count == `ITT_COUNT_RESET) // [RULE6]
		else $error("overflow did not set flag and wrap");
	chk_no_early_ovf: assert property ($rose(r.ovf_flag) |-> $past(r.count) == `ITT_COUNT_MAX && $past(tick)) // [RULE13]
		else $error("flag set without overflow");
	chk_count_step: assert property (tick && !hold_clear |=> r.count == $past(r.count) + 8'h01) // [RULE14]
		else $error("count did not advance by one");
	chk_count_readonly: assert property (!tick && !hold_clear |=> r.count == $past(r.count)) // [RULE1]
		else $error("count changed without a pulse");
	chk_reserved_one: assert property (r.mode[4]) // [RULE9]
		else $error("reserved mode bit not one");
	chk_irq_gate: assert property (irq |-> $past(r.ovf_flag) && $past(r.ovf_enable)) // [RULE15]
		else $error("interrupt without enabled flag");
	chk_pin_enable: assert property (!r.clkout_enable |=> !divided_clock_pin_en ##0 !divided_clock_pin) // [RULE16]
		else $error("clock pin active while disabled");
	chk_sys_out_halt: assert property (!sys_running && !r.mode[`ITT_F_OUT_WATCH] |=> !divided_clock_pin) // [RULE8]
		else $error("system clock output outside active or sleep");
	chk_sub_read: assert property (apb_req.psel && apb_req.penable && !r.rsp.pready && !apb_req.pwrite
		&& index == `ITT_IDX_COUNT && power_mode == ITT_PWR_SUBACTIVE |=> r.rsp.prdata == '0) // [RULE11]
		else $error("count read not blanked in subactive");
	chk_interval_halt: assert property (!r.mode[`ITT_F_TIMEBASE] && !sys_running |-> !tick) // [RULE3]
		else $error("interval count while system clock stopped");

	cov_overflow: cover property (tick && r.count == `ITT_COUNT_MAX ##1 r.ovf_flag);
	cov_timebase_tick: cover property (r.mode[`ITT_F_TIMEBASE] && tick);
	cov_count_read: cover property (access && !apb_req.pwrite && index == `ITT_IDX_COUNT);
	cov_watch_out: cover property (r.mode[`ITT_F_OUT_WATCH] && $rose(divided_clock_pin));

endmodule

// ==== logic/itt_regs.svh ====
// ---------------------------------------------------------------
// register map, field positions, reset values and divider taps
// ---------------------------------------------------------------
// Function
// RULE1: eight-bit read-only up-counter advances once per pulse of the selected source
// RULE2: counter clears to zero on system reset
// RULE3: with bit 3 low, system prescaler taps /8192 down to /8 by bits 2..0
// RULE4: with bit 3 high, bit 2 low, watch prescaler gives 1, 0.5, 0.25, 0.03125 s
// RULE5: bits 3 and 2 both high hold counter and watch prescaler cleared
// RULE6: counter overflow sets the overflow request flag
// RULE7: bits 7..5 pick system /32../4 or watch /32../4 for the clock pin
// RULE8: system-derived clock out only in active and sleep; watch-derived also subactive
// RULE9: mode bit 4 reads as one, writes to it ignored
// RULE10: mode register resets to 0x10
// RULE11: count reads valid in active mode, invalid in subactive mode
// RULE12: writes to the count address are ignored
// RULE13: overflow on first counting pulse after count reached 0xFF
// RULE14: count wraps to zero and keeps counting, one overflow per 256 pulses
// RULE15: interrupt requested only while overflow enable bit is one
// RULE16: clock pin driven only while the clock-out enable bit is one
//
// file holds constants only; included by the package and the bench
`ifndef ITT_REGS_SVH
`define ITT_REGS_SVH

// register indices; byte address is four times the index
`define ITT_IDX_MODE 16'hFFB0
`define ITT_IDX_COUNT 16'hFFB1
`define ITT_IDX_IRQ_STATUS 16'hFFB4
`define ITT_IDX_IRQ_ENABLE 16'hFFB5
`define ITT_IDX_PORT_MODE 16'hFFB6

`define ITT_ADDR_W 18
`define ITT_DATA_W 32
`define ITT_SYS_W 13
`define ITT_WATCH_W 7

`define ITT_MODE_RESET 8'h10
`define ITT_MODE_RSVD_MASK 8'h10
`define ITT_COUNT_RESET 8'h00
`define ITT_COUNT_MAX 8'hFF

// mode register fields, then bit 0 of the interrupt and port mode registers
`define ITT_F_TIMEBASE 3
`define ITT_F_CLEAR 2
`define ITT_F_OUT_HI 7
`define ITT_F_OUT_WATCH 7
`define ITT_F_OVF 0
`define ITT_F_CLKOUT_EN 0

// prescaler taps as log2 of the division
`define ITT_SYS_TAP0 4'hD
`define ITT_SYS_TAP1 4'hC
`define ITT_SYS_TAP2 4'hB
`define ITT_SYS_TAP3 4'h9
`define ITT_SYS_TAP4 4'h8
`define ITT_SYS_TAP5 4'h7
`define ITT_SYS_TAP6 4'h5
`define ITT_SYS_TAP7 4'h3
// watch: 256 counts of watch/128 make 1 s at 32.768 kHz
`define ITT_WATCH_TAP0 4'h7
`define ITT_WATCH_TAP1 4'h6
`define ITT_WATCH_TAP2 4'h5
`define ITT_WATCH_TAP3 4'h2
// clock-out: divide by 32,16,8,4 is prescaler bit 4,3,2,1
`define ITT_OUT_BIT_BASE 3'h4

`endif

// ==== logic/itt_pkg.sv ====
// ---------------------------------------------------------------
// types of the interval / time-base timer
// ---------------------------------------------------------------
// assumes itt_regs.svh is on the include path
package itt_pkg;
`include "itt_regs.svh"

	typedef enum logic [1:0] {
		ITT_PWR_ACTIVE = 2'h0,
		ITT_PWR_SLEEP = 2'h1,
		ITT_PWR_SUBSLEEP = 2'h2,
		ITT_PWR_SUBACTIVE = 2'h3
	} itt_power_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`ITT_ADDR_W-1:0] paddr;
		logic [`ITT_DATA_W-1:0] pwdata;
	} itt_apb_req_type;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [`ITT_DATA_W-1:0] prdata;
	} itt_apb_rsp_type;

	typedef struct packed {
		logic [`ITT_SYS_W-1:0] sys_presc;
		logic [`ITT_WATCH_W-1:0] watch_presc;
		logic watch_prev;
		logic [7:0] mode;
		logic [7:0] count;
		logic ovf_flag;
		logic ovf_enable;
		logic clkout_enable;
		itt_apb_rsp_type rsp;
		logic irq;
		logic clk_out;
		logic clk_out_en;
	} itt_state_type;
endpackage

// ==== tb/tb.sv ====
// ---------------------------------------------------------------
// self-checking bench of the interval / time-base timer
// ---------------------------------------------------------------
// assumes itt_pkg compiled first and itt_regs.svh on the include path
`timescale 1ns/100ps
`include "itt_regs.svh"

module tb
	import itt_pkg::*;
;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	itt_apb_req_type apb_req = '0;
	itt_apb_rsp_type apb_rsp;
	logic watch_clk = 1'b0;
	itt_power_type power_mode = ITT_PWR_ACTIVE;
	logic irq, pin, pin_en, last;
	int failures = 0;
	int n_tests = 0;
	int seed = 68464;
	int cyc = 0;
	int tg, ex;
	int dv[12] = '{8192, 4096, 2048, 512, 256, 128, 32, 8, 512, 256, 128, 16};
	logic [33:0] notes[$];
	logic [33:0] nt;
	logic [31:0] rd, a;
	logic [7:0] dl;
	logic [2:0] m;

	itt_timer dut_u (.mclk(mclk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .watch_clk(watch_clk),
		.power_mode(power_mode), .irq(irq), .divided_clock_pin(pin), .divided_clock_pin_en(pin_en));

	// ---------------------------------------------------------------
	// clock, watch clock, helpers
	// ---------------------------------------------------------------
	initial begin
		forever #5 mclk = ~mclk;
	end

	// watch clock of four mclk periods keeps time-base runs short
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		watch_clk <= cyc[1];
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("comparisons %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
		input logic ck, input logic er, input logic [31:0] exd);
		int t;
		t = 0;
		@(posedge mclk);
		notes.push_back({ck, er, exd});
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'h0}, pwdata: wd};
		@(posedge mclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge mclk);
			t++;
		end while (apb_rsp.pready !== 1'b1 && t < 20);
		check({31'h0, apb_rsp.pready}, 32'h1);
		rd = apb_rsp.prdata;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d, 1'b0, 1'b0, 32'h0);
	endtask

	task automatic rdx(input logic [15:0] idx, input logic [31:0] d);
		apb(1'b0, idx, 32'h0, 1'b1, 1'b0, d);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// ---------------------------------------------------------------
	// response monitor: oldest note against each answer
	// ---------------------------------------------------------------
	always @(posedge mclk) begin
		if (apb_rsp.pready === 1'b1) begin
			nt = notes.pop_front();
			check({31'h0, apb_rsp.pslverr}, {31'h0, nt[32]});
			if (nt[33])
				check(apb_rsp.prdata, nt[31:0]);
		end
	end

	initial begin
		#600000;
		failures++;
		test_done();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		rdx(`ITT_IDX_MODE, 32'h10);
		rdx(`ITT_IDX_COUNT, 32'h0);
		a = $random(seed);
		wr(`ITT_IDX_MODE, {24'h0, a[7:0] & 8'hEF});
		rdx(`ITT_IDX_MODE, {24'h0, a[7:0] | 8'h10});
		apb(1'b1, 16'hFFBF, a, 1'b0, 1'b1, 32'h0);
		apb(1'b0, 16'hFFBF, 32'h0, 1'b1, 1'b1, 32'h0);
		// two reads 2*div apart differ by two whatever the prescaler phase
		for (int c = 0; c < 12; c++) begin
			wr(`ITT_IDX_MODE, (c < 8) ? c : c);
			apb(1'b0, `ITT_IDX_COUNT, 32'h0, 1'b0, 1'b0, 32'h0);
			a = rd;
			wr(`ITT_IDX_COUNT, $random(seed));
			// two register accesses add eight cycles between the two count samples
			wt(2 * dv[c] - 8);
			apb(1'b0, `ITT_IDX_COUNT, 32'h0, 1'b0, 1'b0, 32'h0);
			dl = rd[7:0] - a[7:0];
			check({24'h0, dl}, 32'h2);
		end
		wr(`ITT_IDX_MODE, 32'h0F);
		wt(600);
		rdx(`ITT_IDX_COUNT, 32'h0);
		rdx(`ITT_IDX_MODE, 32'h1F);
		wr(`ITT_IDX_MODE, 32'h0B);
		wt(100);
		power_mode <= ITT_PWR_SUBACTIVE;
		rdx(`ITT_IDX_COUNT, 32'h0);
		power_mode <= ITT_PWR_ACTIVE;
		wr(`ITT_IDX_MODE, 32'h0C);
		wr(`ITT_IDX_IRQ_STATUS, 32'h1);
		wr(`ITT_IDX_IRQ_ENABLE, 32'h0);
		wr(`ITT_IDX_MODE, 32'h0B);
		tg = cyc;
		for (int k = 1; k < 3; k++) begin
			while (cyc < tg + (256 * k - 4) * 16) @(posedge mclk);
			rdx(`ITT_IDX_IRQ_STATUS, 32'h0);
			while (cyc < tg + (256 * k + 4) * 16) @(posedge mclk);
			rdx(`ITT_IDX_IRQ_STATUS, 32'h1);
			check({31'h0, irq}, 32'h0);
			wr(`ITT_IDX_IRQ_ENABLE, 32'h1);
			wt(3);
			check({31'h0, irq}, 32'h1);
			wr(`ITT_IDX_IRQ_STATUS, 32'h1);
			wt(3);
			check({31'h0, irq}, 32'h0);
			wr(`ITT_IDX_IRQ_ENABLE, 32'h0);
		end
		wr(`ITT_IDX_PORT_MODE, 32'h1);
		wt(3);
		check({31'h0, pin_en}, 32'h1);
		// last two passes: system and watch outputs in subactive
		for (int c = 0; c < 10; c++) begin
			m = (c < 8) ? c : ((c == 8) ? 3'h3 : 3'h7);
			if (c == 8)
				power_mode <= ITT_PWR_SUBACTIVE;
			wr(`ITT_IDX_MODE, {24'h0, m, 5'h0B});
			wt(8);
			tg = 0;
			last = pin;
			for (int i = 0; i < 128; i++) begin
				@(posedge mclk);
				if (pin !== last)
					tg++;
				last = pin;
			end
			ex = (c == 8) ? 0 : ((m < 4) ? (8 << m) : (2 << (m - 4)));
			check({31'h0, tg >= ex - 1 && tg <= ex + 1}, 32'h1);
		end
		power_mode <= ITT_PWR_ACTIVE;
		wr(`ITT_IDX_PORT_MODE, 32'h0);
		wt(3);
		check({30'h0, pin_en, pin}, 32'h0);
		test_done();
	end
endmodule
